//--- hw/mpgio_top.sv
// Purpose: keypad, peripheral and display gpio ports with apb access
// Assumes: only keypad pins pass the synchroniser, peripheral and display pins sampled directly, apb slave
// Notes:   pin output enables are active low (low = driving)
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: one global bit enables all keypad pull-ups
// R2: output keypad pins lose their pull-up
// R3: power-on reset leaves pull-ups disabled
// R4: only pins 4-7 as inputs watched
// R5: watched inputs compared with read latch
// R6: change mismatch raises the wake request
// R7: keypad data access refreshes compare latch
// R8: mismatch keeps setting flag; read first
// R9: software avoids polling during change detection
// R10: pin 0 doubles as external interrupt
// R11: pins 6,7 carry serial programming lines
// R12: peripheral port six bits, upper read zero
// R13: enabled peripheral overrides pin direction
// R14: avoid read-modify-write on overridden direction
// R15: peripheral pins shared with timer, ccp, serial
// R16: display low five bidirectional, upper input-only
// R17: display direction applies pins 0-4, digital only
// R18: power-on reset selects lcd drivers everywhere
// R19: set segment-enable keeps pins as lcd
// R20: keypad ttl, others schmitt buffers
// R21: direction set means input, clear drives
// R22: data read returns pins, write sets latch
// R23: watched inputs synchronised before comparison
// R24: display pins 5-7 never driven digitally
module mpgio_top
    import mpgio_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic [7:0]        keypadPortIn,
    output logic [7:0]             keypadPortOut,
    output logic [7:0]             keypadPortOe_b,
    output logic [7:0]             keypadPullupEn,
    output logic [7:0]             keypadSchmittEn,
    input  wire logic              extIrqEnable,
    input  wire logic              serialProgMode,
    output logic                   externalIrqPin,
    output logic                   portChangeWake,
    input  wire logic [5:0]        peripheralPortIn,
    output logic [5:0]             peripheralPortOut,
    output logic [5:0]             peripheralPortOe_b,
    input  wire logic [5:0]        periphOutData,
    output logic [5:0]             periphInData,
    input  wire logic [7:0]        displayPortIn,
    output logic [7:0]             displayPortOut,
    output logic [7:0]             displayPortOe_b,
    output logic [7:0]             displayLcdSel
);
    typedef struct packed {
        mpgio_phase_t phase;
        logic         ready;
        logic [31:0]  rdata;
        logic         slverr;
        logic [7:0]   kpLatch;
        logic [7:0]   kpDir;
        logic [7:0]   options;
        logic [7:0]   kpCompare;
        logic         changeFlag;
        logic [5:0]   pcLatch;
        logic [5:0]   pcDir;
        logic [5:0]   pcOvrEn;
        logic [5:0]   pcOvrDir;
        logic [7:0]   pdLatch;
        logic [7:0]   pdDir;
        logic [1:0]   segEn;
        logic [7:0]   kpOut;
        logic [7:0]   kpOe_b;
        logic [7:0]   kpPull;
        logic [7:0]   kpSchmitt;
        logic         extIrq;
        logic         wake;
        logic [5:0]   pcOut;
        logic [5:0]   pcOe_b;
        logic [5:0]   pcIn;
        logic [7:0]   pdOut;
        logic [7:0]   pdOe_b;
        logic [7:0]   pdLcd;
    } mpgio_state_t;

    mpgio_state_t st;
    mpgio_state_t next_st;
    logic [7:0]   kpSync;
    logic [7:0]   kpPullDec;
    logic [5:0]   pcEffDir;
    logic [7:0]   pdLcdDec;
    logic [7:0]   pdEffDir;
    logic [7:0]   mismatch;
    logic         accessEdge;
    logic         wrEdge;
    logic         rdEdge;
    logic [9:0]   regIdx;

    function automatic logic hitIdx(input logic [9:0] idx,
                                    input logic [9:0] want);
        hitIdx = (idx == want);
    endfunction

    mpgio_sync #(.W(8)) u_kp_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .asyncIn (keypadPortIn),
        .syncOut (kpSync) // R23
    );

    mpgio_pin_mux u_mux (
        .keypadDir     (st.kpDir),
        .pullupDisable (st.options[POS_PULLUP_DIS]),
        .periphDir     (st.pcDir),
        .periphOvrEn   (st.pcOvrEn),
        .periphOvrDir  (st.pcOvrDir),
        .displayDir    (st.pdDir),
        .segEnable     (st.segEn),
        .keypadPullup  (kpPullDec),
        .periphEffDir  (pcEffDir),
        .displayLcd    (pdLcdDec),
        .displayEffDir (pdEffDir)
    );

    assign regIdx     = paddr[ADDR_W-1:2];
    assign accessEdge = psel && penable && st.ready;
    assign wrEdge     = accessEdge && pwrite;
    assign rdEdge     = accessEdge && !pwrite;
    // watched input pins that differ from the latched copy
    assign mismatch   = (kpSync ^ st.kpCompare) & st.kpDir & WATCH_MASK; // R4 R5

    always_comb begin
        next_st = st;
        // apb: no wait state, answer in the first access cycle
        unique case (st.phase)
            MPG_IDLE: begin
                next_st.ready = 1'b0;
                if (psel && !penable) begin
                    next_st.phase = MPG_ACCESS;
                    next_st.ready = 1'b1;
                end
            end
            MPG_ACCESS: begin
                next_st.phase = MPG_IDLE;
                next_st.ready = 1'b0;
            end
        endcase
        next_st.rdata  = '0;
        next_st.slverr = 1'b0;
        if (psel && !penable) begin
            unique case (1'b1)
                hitIdx(regIdx, IDX_KEYPAD_PINS):
                    next_st.rdata[7:0] = kpSync; // R22
                hitIdx(regIdx, IDX_PERIPH_PINS):
                    next_st.rdata[5:0] = peripheralPortIn; // R12 R22
                hitIdx(regIdx, IDX_DISPLAY_PINS):
                    next_st.rdata[7:0] = displayPortIn;
                hitIdx(regIdx, IDX_OPTIONS):
                    next_st.rdata[7:0] = st.options;
                hitIdx(regIdx, IDX_KEYPAD_DIR):
                    next_st.rdata[7:0] = st.kpDir;
                hitIdx(regIdx, IDX_PERIPH_DIR):
                    next_st.rdata[5:0] = pcEffDir; // R12
                hitIdx(regIdx, IDX_DISPLAY_DIR):
                    next_st.rdata[7:0] = st.pdDir;
                hitIdx(regIdx, IDX_SEG_ENABLE):
                    next_st.rdata[1:0] = st.segEn;
                hitIdx(regIdx, IDX_IRQ_CONTROL):
                    next_st.rdata[POS_CHANGE_FLAG] = st.changeFlag;
                hitIdx(regIdx, IDX_PERIPH_OVR):
                    next_st.rdata[11:0] = {st.pcOvrDir, st.pcOvrEn};
                default:
                    next_st.slverr = 1'b1;
            endcase
        end else if (st.phase == MPG_ACCESS) begin
            next_st.rdata  = st.rdata;
            next_st.slverr = st.slverr;
        end
        if (wrEdge) begin
            unique case (1'b1)
                hitIdx(regIdx, IDX_KEYPAD_PINS):
                    next_st.kpLatch = pwdata[7:0]; // R22
                hitIdx(regIdx, IDX_PERIPH_PINS):
                    next_st.pcLatch = pwdata[5:0];
                hitIdx(regIdx, IDX_DISPLAY_PINS):
                    next_st.pdLatch = pwdata[7:0];
                hitIdx(regIdx, IDX_OPTIONS):
                    next_st.options = pwdata[7:0];
                hitIdx(regIdx, IDX_KEYPAD_DIR):
                    next_st.kpDir = pwdata[7:0];
                hitIdx(regIdx, IDX_PERIPH_DIR):
                    next_st.pcDir = pwdata[5:0];
                hitIdx(regIdx, IDX_DISPLAY_DIR):
                    next_st.pdDir = pwdata[7:0];
                hitIdx(regIdx, IDX_SEG_ENABLE):
                    next_st.segEn = pwdata[1:0];
                hitIdx(regIdx, IDX_IRQ_CONTROL):
                    if (!pwdata[POS_CHANGE_FLAG]) begin
                        next_st.changeFlag = 1'b0;
                    end
                hitIdx(regIdx, IDX_PERIPH_OVR): begin
                    next_st.pcOvrEn  = pwdata[5:0];
                    next_st.pcOvrDir = pwdata[11:6];
                end
                default: begin
                end
            endcase
        end
        // any keypad data access ends the mismatch
        if (accessEdge && hitIdx(regIdx, IDX_KEYPAD_PINS)) begin
            next_st.kpCompare = kpSync; // R7
        end
        // set beats clear while mismatch persists
        if (|mismatch) begin
            next_st.changeFlag = 1'b1; // R5 R8
        end
        next_st.wake      = |mismatch; // R6
        next_st.kpOut     = st.kpLatch;
        next_st.kpOe_b    = st.kpDir; // R21
        next_st.kpPull    = kpPullDec; // R1 R2
        next_st.kpSchmitt = {serialProgMode, serialProgMode, 5'h00,
                             extIrqEnable}; // R10 R11 R20
        next_st.extIrq    = kpSync[POS_EXT_IRQ_PIN]; // R10
        // peripheral drives its own data when it overrides
        for (int i = 0; i < 6; i++) begin
            next_st.pcOut[i] = st.pcOvrEn[i] ? periphOutData[i]
                                             : st.pcLatch[i]; // R15
        end
        next_st.pcOe_b = pcEffDir; // R13 R21
        next_st.pcIn   = peripheralPortIn;
        next_st.pdOut  = st.pdLatch;
        next_st.pdOe_b = pdEffDir; // R16 R17 R24
        next_st.pdLcd  = pdLcdDec; // R19
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st            <= '0;
            st.phase      <= MPG_IDLE;
            st.options    <= RST_OPTIONS; // R3
            st.kpDir      <= RST_KEYPAD_DIR;
            st.kpOe_b     <= RST_KEYPAD_DIR;
            st.kpPull     <= RST_ZERO8; // R3
            st.pcDir      <= RST_PERIPH_DIR;
            st.pcOe_b     <= RST_PERIPH_DIR;
            st.pdDir      <= RST_DISPLAY_DIR;
            st.pdOe_b     <= RST_DISPLAY_DIR;
            st.pdLatch    <= RST_DISPLAY_LAT;
            st.segEn      <= RST_SEG_ENABLE; // R18
            st.pdLcd      <= RST_DISPLAY_DIR; // R18
        end else begin
            st <= next_st;
        end
    end

    assign pready             = st.ready;
    assign prdata             = st.rdata;
    assign pslverr            = st.slverr;
    assign keypadPortOut      = st.kpOut;
    assign keypadPortOe_b     = st.kpOe_b;
    assign keypadPullupEn     = st.kpPull;
    assign keypadSchmittEn    = st.kpSchmitt;
    assign externalIrqPin     = st.extIrq;
    assign portChangeWake     = st.wake;
    assign peripheralPortOut  = st.pcOut;
    assign peripheralPortOe_b = st.pcOe_b;
    assign periphInData       = st.pcIn;
    assign displayPortOut     = st.pdOut;
    assign displayPortOe_b    = st.pdOe_b;
    assign displayLcdSel      = st.pdLcd;

    property p_pullup_off_output;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.kpDir != RST_KEYPAD_DIR)
            |=> (keypadPullupEn & ~$past(st.kpDir)) == RST_ZERO8;
    endproperty
    a_pullup_off_output: assert property (p_pullup_off_output) // R2
        else $error("pull-up on while pin is output");

    property p_pullup_global;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.options[POS_PULLUP_DIS] && $stable(st.options))
            |=> keypadPullupEn == RST_ZERO8;
    endproperty
    a_pullup_global: assert property (p_pullup_global) // R1
        else $error("pull-up on while globally disabled");

    property p_mismatch_sets;
        @(posedge sys_clk) disable iff (!rst_b)
        (|mismatch) |=> st.changeFlag;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) // R8
        else $error("mismatch did not set change flag");

    property p_output_excluded;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.kpDir[7:4] == 4'h0) |-> !(|mismatch);
    endproperty
    a_output_excluded: assert property (p_output_excluded) // R4
        else $error("output pin took part in change compare");

    property p_refresh;
        @(posedge sys_clk) disable iff (!rst_b)
        (accessEdge && hitIdx(regIdx, IDX_KEYPAD_PINS))
            |=> st.kpCompare == $past(kpSync);
    endproperty
    a_refresh: assert property (p_refresh) // R7
        else $error("compare latch not refreshed");

    property p_wake;
        @(posedge sys_clk) disable iff (!rst_b)
        (|mismatch) |=> portChangeWake;
    endproperty
    a_wake: assert property (p_wake) // R6
        else $error("no wake on mismatch");

    property p_display_high_in;
        @(posedge sys_clk) disable iff (!rst_b)
        ##1 displayPortOe_b[7:5] == 3'h7;
    endproperty
    a_display_high_in: assert property (p_display_high_in) // R24
        else $error("display upper pins driven");

    property p_segment_blocks;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.segEn[POS_SEG_LOW] && $stable(st.segEn))
            |=> displayPortOe_b[4:0] == 5'h1F;
    endproperty
    a_segment_blocks: assert property (p_segment_blocks) // R19
        else $error("lcd pin driven digitally");

    property p_periph_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (pready && !pwrite && psel && penable) |-> prdata[31:12] == 20'h0;
    endproperty
    a_periph_zero: assert property (p_periph_zero) // R12
        else $error("upper read data not zero");

    c_flag: cover property (@(posedge sys_clk) st.changeFlag);
    c_wake: cover property (@(posedge sys_clk) portChangeWake);
    c_write: cover property (@(posedge sys_clk) wrEdge);
    c_err: cover property (@(posedge sys_clk) pslverr && pready);
endmodule
`default_nettype wire

//--- hw/mpgio_pkg.sv
// Purpose: constants for the three-port gpio block
// Assumes: apb word registers, byte address = 4 * printed index
// Notes:   display/peripheral/interrupt offsets are local choices
package mpgio_pkg;
    localparam int unsigned ADDR_W = 12;
    // printed register indices
    localparam logic [9:0] IDX_KEYPAD_PINS   = 10'h006;
    localparam logic [9:0] IDX_PERIPH_PINS   = 10'h007;
    localparam logic [9:0] IDX_OPTIONS       = 10'h081;
    localparam logic [9:0] IDX_KEYPAD_DIR    = 10'h086;
    localparam logic [9:0] IDX_PERIPH_DIR    = 10'h087;
    localparam logic [9:0] IDX_DISPLAY_PINS  = 10'h008;
    localparam logic [9:0] IDX_DISPLAY_DIR   = 10'h088;
    localparam logic [9:0] IDX_SEG_ENABLE    = 10'h10D;
    localparam logic [9:0] IDX_IRQ_CONTROL   = 10'h00B;
    localparam logic [9:0] IDX_PERIPH_OVR    = 10'h0C0;
    // reset values
    localparam logic [7:0] RST_OPTIONS     = 8'hFF;
    localparam logic [7:0] RST_KEYPAD_DIR  = 8'hFF;
    localparam logic [5:0] RST_PERIPH_DIR  = 6'h3F;
    localparam logic [7:0] RST_DISPLAY_DIR = 8'hFF;
    localparam logic [7:0] RST_DISPLAY_LAT = 8'h00;
    localparam logic [1:0] RST_SEG_ENABLE  = 2'h3;
    localparam logic [7:0] RST_ZERO8       = 8'h00;
    localparam logic [5:0] RST_ZERO6       = 6'h00;
    // field positions
    localparam int unsigned POS_PULLUP_DIS  = 7;
    localparam int unsigned POS_CHANGE_FLAG = 0;
    localparam int unsigned POS_EXT_IRQ_PIN = 0;
    localparam int unsigned POS_SEG_LOW     = 0;
    localparam int unsigned POS_SEG_HIGH    = 1;
    localparam int unsigned DISP_IO_PINS    = 5;
    localparam logic [7:0]  WATCH_MASK      = 8'hF0;
    localparam logic [7:0]  PROG_PIN_MASK   = 8'hC0;
    typedef enum logic [1:0] {MPG_IDLE, MPG_ACCESS} mpgio_phase_t;
endpackage

//--- hw/mpgio_sync.sv
// Purpose: two-flop synchroniser for a pin vector
// Assumes: one clock, asynchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module mpgio_sync
    import mpgio_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] asyncIn,
    output var  logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } mpgio_sync_t;
    mpgio_sync_t st;
    mpgio_sync_t next_st;
    always_comb begin
        next_st.meta   = asyncIn;
        next_st.stable = st.meta;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign syncOut = st.stable;
endmodule
`default_nettype wire

//--- hw/mpgio_pin_mux.sv
// Purpose: drive-enable and pull-up decode per pin group
// Assumes: direction bit high means input
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module mpgio_pin_mux
    import mpgio_pkg::*;
(
    input  wire logic [7:0] keypadDir,
    input  wire logic       pullupDisable,
    input  wire logic [5:0] periphDir,
    input  wire logic [5:0] periphOvrEn,
    input  wire logic [5:0] periphOvrDir,
    input  wire logic [7:0] displayDir,
    input  wire logic [1:0] segEnable,
    output var  logic [7:0] keypadPullup,
    output var  logic [5:0] periphEffDir,
    output var  logic [7:0] displayLcd,
    output var  logic [7:0] displayEffDir
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_kp
            // pull-up only on input pins while globally enabled
            assign keypadPullup[i] = !pullupDisable && keypadDir[i]; // R1 R2
        end
        for (i = 0; i < 6; i++) begin : g_pc
            // enabled peripheral overrides the direction bit
            assign periphEffDir[i] = periphOvrEn[i] ? periphOvrDir[i]
                                                    : periphDir[i]; // R13
        end
        for (i = 0; i < 8; i++) begin : g_pd
            if (i < DISP_IO_PINS) begin : g_io
                assign displayLcd[i] = segEnable[POS_SEG_LOW]; // R19
                assign displayEffDir[i] = displayLcd[i] | displayDir[i]; // R17
            end else begin : g_in
                assign displayLcd[i] = segEnable[POS_SEG_HIGH]; // R19
                assign displayEffDir[i] = 1'b1; // R24
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- test/mpgio_pin_model.sv
// Purpose: external pin circuitry for the three gpio ports
// Assumes: keys pull low, a floating keypad pin wanders every cycle
// Notes:   a driven pin reads back the device's own output
`timescale 1ns/1ps
`default_nettype none
module mpgio_pin_model (
    input  wire logic [7:0] keyPress,
    input  wire logic       sys_clk,
    input  wire logic [7:0] keypadPortOut,
    input  wire logic [7:0] keypadPortOe_b,
    input  wire logic [7:0] keypadPullupEn,
    output var  logic [7:0] keypadPortIn,
    input  wire logic [5:0] periphExt,
    input  wire logic [5:0] peripheralPortOut,
    input  wire logic [5:0] peripheralPortOe_b,
    output var  logic [5:0] peripheralPortIn,
    input  wire logic [7:0] displayExt,
    input  wire logic [7:0] displayPortOut,
    input  wire logic [7:0] displayPortOe_b,
    output var  logic [7:0] displayPortIn
);
    logic [7:0] floatPat = 8'h55;
    always @(posedge sys_clk) begin
        floatPat <= ~floatPat;
    end
    // driver wins, then key, then pull-up, else wandering level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!keypadPortOe_b[i])
                keypadPortIn[i] = keypadPortOut[i];
            else if (keyPress[i])
                keypadPortIn[i] = 1'b0;
            else if (keypadPullupEn[i])
                keypadPortIn[i] = 1'b1;
            else
                keypadPortIn[i] = floatPat[i];
        end
    end
    assign peripheralPortIn = (peripheralPortOut & ~peripheralPortOe_b)
                            | (periphExt & peripheralPortOe_b);
    assign displayPortIn = (displayPortOut & ~displayPortOe_b)
                         | (displayExt & displayPortOe_b);
endmodule
`default_nettype wire

//--- test/mpgio_top_tb.sv
// Purpose: self-checking bench for the three-port gpio block
// Assumes: apb answers after one access cycle, byte address = 4 * index
// Notes:   reset checks first, then register table, then hand-written pin scenarios
`timescale 1ns/1ps
`default_nettype none
module mpgio_top_tb
    import mpgio_pkg::*;
;
    typedef struct {logic w; logic [9:0] idx; logic [31:0] d, e; logic er;}
        mpgio_row_t;
    logic              sys_clk, rst_b, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdv;
    logic              pready, pslverr, erv, extIrqEnable, serialProgMode;
    logic              externalIrqPin, portChangeWake;
    logic [7:0]        keyPress, kIn, kOut, kOe_b, kPull, kSchmitt;
    logic [5:0]        periphExt, pIn, pOut, pOe_b, periphOutData, pData;
    logic [7:0]        displayExt, dIn, dOut, dOe_b, dLcd;
    int                errors = 0;
    int                n_tests = 0;
    mpgio_row_t        rows[12] = '{
        '{0, IDX_OPTIONS, 0, 32'hFF, 0}, '{0, IDX_KEYPAD_DIR, 0, 32'hFF, 0},
        '{0, IDX_PERIPH_DIR, 0, 32'h3F, 0}, '{0, IDX_DISPLAY_DIR, 0, 32'hFF, 0},
        '{0, IDX_SEG_ENABLE, 0, 32'h03, 0}, '{0, 10'h3FF, 0, 0, 1},
        '{1, IDX_PERIPH_DIR, 32'hFF, 0, 0}, '{0, IDX_PERIPH_DIR, 0, 32'h3F, 0},
        '{1, 10'h3FF, 32'h55, 0, 1}, '{1, IDX_KEYPAD_DIR, 32'h0F, 0, 0},
        '{0, IDX_KEYPAD_DIR, 0, 32'h0F, 0}, '{1, IDX_OPTIONS, 32'h7F, 0, 0}};

    mpgio_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .keypadPortIn(kIn), .keypadPortOut(kOut), .keypadPortOe_b(kOe_b),
        .keypadPullupEn(kPull), .keypadSchmittEn(kSchmitt),
        .extIrqEnable(extIrqEnable), .serialProgMode(serialProgMode),
        .externalIrqPin(externalIrqPin), .portChangeWake(portChangeWake),
        .peripheralPortIn(pIn), .peripheralPortOut(pOut),
        .peripheralPortOe_b(pOe_b), .periphOutData(periphOutData),
        .periphInData(pData), .displayPortIn(dIn), .displayPortOut(dOut),
        .displayPortOe_b(dOe_b), .displayLcdSel(dLcd));
    mpgio_pin_model pins (.sys_clk(sys_clk), .keyPress(keyPress),
        .keypadPortOut(kOut), .keypadPortOe_b(kOe_b), .keypadPullupEn(kPull),
        .keypadPortIn(kIn), .periphExt(periphExt), .peripheralPortOut(pOut),
        .peripheralPortOe_b(pOe_b), .peripheralPortIn(pIn),
        .displayExt(displayExt), .displayPortOut(dOut),
        .displayPortOe_b(dOe_b), .displayPortIn(dIn));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        chk("waits", 1, n);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [9:0] idx,
                         input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk(nm, e, rdv);
    endtask
    task automatic settle(input string nm);
        repeat (5) @(posedge sys_clk);
        $display("test %s done", nm);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {extIrqEnable, serialProgMode, keyPress} = '0;
        {periphExt, periphOutData, displayExt} = {6'h2A, 6'h15, 8'hA0};
        rst_b = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle("reset");
        chk("pullups", 8'h00, kPull);
        chk("lcdsel", 8'hFF, dLcd);
        chk("keyoe", 8'hFF, kOe_b);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].d);
            chk("slverr", rows[i].er, erv);
            if (!rows[i].w && !rows[i].er) chk("reg", rows[i].e, rdv);
        end
        settle("table");
        chk("pullups", 8'h0F, kPull);
        chk("keyoe", 8'h0F, kOe_b);
        apb(1, IDX_KEYPAD_PINS, 32'hA5);
        settle("latch");
        chk("keyout", 8'hA5, kOut);
        rdchk("keypins", IDX_KEYPAD_PINS, 32'hAF);
        apb(1, IDX_IRQ_CONTROL, 0);
        apb(1, IDX_KEYPAD_PINS, 32'h55);
        keyPress <= 8'h02;
        settle("excluded");
        chk("wake", 0, portChangeWake);
        rdchk("flag", IDX_IRQ_CONTROL, 0);
        keyPress <= 8'h00;
        apb(1, IDX_KEYPAD_DIR, 32'hFF);
        settle("inputs");
        rdchk("keypins", IDX_KEYPAD_PINS, 32'hFF);
        apb(1, IDX_IRQ_CONTROL, 0);
        rdchk("flag", IDX_IRQ_CONTROL, 0);
        keyPress <= 8'h20;
        settle("press");
        chk("wake", 1, portChangeWake);
        rdchk("flag", IDX_IRQ_CONTROL, 1);
        apb(1, IDX_IRQ_CONTROL, 0);
        rdchk("flag", IDX_IRQ_CONTROL, 1);
        rdchk("keypins", IDX_KEYPAD_PINS, 32'hDF);
        settle("refresh");
        chk("wake", 0, portChangeWake);
        apb(1, IDX_IRQ_CONTROL, 0);
        rdchk("flag", IDX_IRQ_CONTROL, 0);
        {extIrqEnable, serialProgMode, keyPress} <= {2'b11, 8'h01};
        settle("schmitt");
        chk("schmitt", 8'hC1, kSchmitt);
        chk("extirq", 0, externalIrqPin);
        apb(1, IDX_PERIPH_OVR, 32'hEC4);
        settle("override");
        rdchk("pdir", IDX_PERIPH_DIR, 32'h3B);
        chk("poe", 6'h3B, pOe_b);
        chk("pout2", 1, pOut[2]);
        chk("pdata", 6'h2E, pData);
        rdchk("ppins", IDX_PERIPH_PINS, 32'h2E);
        apb(1, IDX_DISPLAY_DIR, 0);
        apb(1, IDX_DISPLAY_PINS, 32'h1F);
        settle("lcd");
        chk("doe", 8'hFF, dOe_b);
        apb(1, IDX_SEG_ENABLE, 32'h2);
        settle("lowdigital");
        chk("lcdsel", 8'hE0, dLcd);
        chk("doe", 8'hE0, dOe_b);
        apb(1, IDX_SEG_ENABLE, 0);
        settle("digital");
        chk("lcdsel", 8'h00, dLcd);
        chk("doe", 8'hE0, dOe_b);
        chk("dout", 8'h1F, dOut);
        rdchk("dpins", IDX_DISPLAY_PINS, 32'hBF);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle("midreset");
        chk("pullups", 8'h00, kPull);
        chk("lcdsel", 8'hFF, dLcd);
        chk("doe", 8'hFF, dOe_b);
        rdchk("options", IDX_OPTIONS, 32'hFF);
        tally_and_finish();
    end
endmodule
`default_nettype wire
